/* design/oc7_consts.svh */
// Constants for the output 7 channel control register block.
// What this block does
// - Source field picks channel 7 feed: PLL1, PLL2, primary or secondary ref.
// - Reference sources bypass the channel divider; only PLL sources are divided.
// - Format field: 0 off, 1 AC differential, 2 HCSL, 3 single-ended CMOS.
// - In CMOS format positive pin: tri-state, low, inverted or true.
// - In CMOS format negative pin: tri-state, low, inverted or true.
// - Reset loads PLL1, differential, mode1 2, mode2 0; fields RW, NVM-backed.
`ifndef OC7_CONSTS_SVH
`define OC7_CONSTS_SVH
`define OC7_CTL_INDEX      30'h0000002b
`define OC7_STAT_INDEX     30'h00000030
`define OC7_CTL_RESET      8'h18
`define OC7_SRC_MSB        7
`define OC7_SRC_LSB        6
`define OC7_FMT_MSB        5
`define OC7_FMT_LSB        4
`define OC7_MODEP_MSB      3
`define OC7_MODEP_LSB      2
`define OC7_MODEN_MSB      1
`define OC7_MODEN_LSB      0
`define OC7_HTRANS_NONSEQ  2'h2
`define OC7_HTRANS_SEQ     2'h3
`endif

/* design/oc7_output7_control.sv */
// Output 7 channel control register, source mux, divider and pin drivers.
//
// Added by the designer: register access over AHB-Lite.
`include "oc7_consts.svh"
`default_nettype none
module oc7_output7_control (
    // Clock and reset.
    input  wire  logic        I_CORE_CLK,
    input  wire  logic        I_RESET_N,
    // AHB-Lite slave.
    input  wire  logic        I_HSEL,
    input  wire  logic [31:0] I_HADDR,
    input  wire  logic [1:0]  I_HTRANS,
    input  wire  logic        I_HWRITE,
    input  wire  logic [2:0]  I_HSIZE,
    input  wire  logic [31:0] I_HWDATA,
    input  wire  logic        I_HREADY,
    output logic        [31:0] O_HRDATA,
    output logic               O_HREADYOUT,
    output logic               O_HRESP,
    // Nonvolatile store.
    input  wire  logic        I_NVM_LOAD,
    input  wire  logic [7:0]  I_NVM_DATA,
    output logic        [7:0]  O_NVM_DATA,
    // Clock sources, asynchronous levels.
    input  wire  logic        I_PLL1_CLK,
    input  wire  logic        I_PLL2_CLK,
    input  wire  logic        I_PRI_REF,
    input  wire  logic        I_SEC_REF,
    // Divider ratio, value n divides by n plus one.
    input  wire  logic [7:0]  I_DIV_RATIO,
    // Channel pins and driver settings.
    output logic               O_P_OUT,
    output logic               O_P_OE,
    output logic               O_N_OUT,
    output logic               O_N_OE,
    output logic        [1:0]  O_FORMAT,
    output logic        [1:0]  O_POS_MODE,
    output logic        [1:0]  O_NEG_MODE,
    output logic               O_DIV_BYPASS
);

    // True when the selected source is a reference.
    function automatic logic is_ref(input logic [1:0] sel);
        is_ref = (sel == oc7_pkg::OC7_SRC_PRIREF) ||
                 (sel == oc7_pkg::OC7_SRC_SECREF);
    endfunction

    // Drive level and enable of one CMOS pin for a mode.
    function automatic logic [1:0] pin_drive(input logic [1:0] mode,
                                             input logic       chan);
        case (mode)
            oc7_pkg::OC7_PIN_TRI:  pin_drive = 2'h0;
            oc7_pkg::OC7_PIN_LOW:  pin_drive = 2'h2;
            oc7_pkg::OC7_PIN_INV:  pin_drive = {1'b1, ~chan};
            default:               pin_drive = {1'b1, chan};
        endcase
    endfunction

    // Bus state.
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    logic [29:0] wr_idx_ff;
    logic [29:0] nxt_wr_idx;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0]  ctl_ff;
    logic [7:0]  nxt_ctl;
    logic        addr_ok;
    logic        ctl_wr;

    // Channel state.
    logic [3:0]  sync1_ff;
    logic [3:0]  sync2_ff;
    logic        prev_ff;
    logic        nxt_prev;
    logic [7:0]  cnt_ff;
    logic [7:0]  nxt_cnt;
    logic [3:0]  pins_ff;
    logic [3:0]  nxt_pins;
    logic        src_w;
    logic        div_w;
    logic        chan_w;

    logic [1:0]  src_sel;
    logic [1:0]  fmt_sel;
    logic [1:0]  modep;
    logic [1:0]  moden;
    logic        bypass_w;

    assign src_sel  = ctl_ff[`OC7_SRC_MSB:`OC7_SRC_LSB];
    assign fmt_sel  = ctl_ff[`OC7_FMT_MSB:`OC7_FMT_LSB];
    assign modep    = ctl_ff[`OC7_MODEP_MSB:`OC7_MODEP_LSB];
    assign moden    = ctl_ff[`OC7_MODEN_MSB:`OC7_MODEN_LSB];
    assign bypass_w = is_ref(src_sel);

    assign addr_ok = I_HSEL && I_HREADY &&
                     ((I_HTRANS == `OC7_HTRANS_NONSEQ) ||
                      (I_HTRANS == `OC7_HTRANS_SEQ));
    assign ctl_wr  = wr_pend_ff && (wr_idx_ff == `OC7_CTL_INDEX);

    // Bus and register next values. A write in its data phase is
    // forwarded to a read whose address phase shares that cycle.
    always_comb begin
        nxt_wr_pend = 1'b0;
        nxt_wr_idx  = wr_idx_ff;
        nxt_rdata   = rdata_ff;
        nxt_ctl     = ctl_ff;
        if (I_NVM_LOAD) begin
            nxt_ctl = I_NVM_DATA;
        end else if (ctl_wr) begin
            nxt_ctl = I_HWDATA[7:0];
        end
        if (addr_ok) begin
            nxt_wr_pend = I_HWRITE;
            nxt_wr_idx  = I_HADDR[31:2];
            nxt_rdata   = 32'h00000000;
            if (!I_HWRITE) begin
                if (I_HADDR[31:2] == `OC7_CTL_INDEX) begin
                    nxt_rdata = {24'h000000, nxt_ctl};
                end else if (I_HADDR[31:2] == `OC7_STAT_INDEX) begin
                    nxt_rdata = {24'h000000, pins_ff, 1'b0,
                                 bypass_w, src_w, chan_w};
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 30'h00000000;
            rdata_ff   <= 32'h00000000;
            ctl_ff     <= `OC7_CTL_RESET;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_idx_ff  <= nxt_wr_idx;
            rdata_ff   <= nxt_rdata;
            ctl_ff     <= nxt_ctl;
        end
    end

    // Source levels come from other clock domains.
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {I_SEC_REF, I_PRI_REF, I_PLL2_CLK, I_PLL1_CLK};
            sync2_ff <= sync1_ff;
        end
    end

    assign src_w  = sync2_ff[src_sel];
    assign div_w  = (I_DIV_RATIO == 8'h00) ? src_w :
                    (cnt_ff <= {1'b0, I_DIV_RATIO[7:1]});
    assign chan_w = bypass_w ? src_w : div_w;

    // Divider counts rising edges of the selected PLL source.
    always_comb begin
        nxt_prev = src_w;
        nxt_cnt  = cnt_ff;
        if (bypass_w) begin
            nxt_cnt = 8'h00;
        end else if (src_w && !prev_ff) begin
            nxt_cnt = (cnt_ff >= I_DIV_RATIO) ? 8'h00 : cnt_ff + 8'h01;
        end
    end

    // Pin drive: {p_oe, p_out, n_oe, n_out}.
    always_comb begin
        nxt_pins = 4'h0;
        case (fmt_sel)
            oc7_pkg::OC7_FMT_OFF: begin
                nxt_pins = 4'h0;
            end
            oc7_pkg::OC7_FMT_CMOS: begin
                nxt_pins = {pin_drive(modep, chan_w),
                            pin_drive(moden, chan_w)};
            end
            default: begin
                nxt_pins = {1'b1, chan_w, 1'b1, ~chan_w};
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            prev_ff <= 1'b0;
            cnt_ff  <= 8'h00;
            pins_ff <= 4'h0;
        end else begin
            prev_ff <= nxt_prev;
            cnt_ff  <= nxt_cnt;
            pins_ff <= nxt_pins;
        end
    end

    assign O_HRDATA     = rdata_ff;
    assign O_HREADYOUT  = 1'b1;
    assign O_HRESP      = 1'b0;
    assign O_NVM_DATA   = ctl_ff;
    assign O_P_OE       = pins_ff[3];
    assign O_P_OUT      = pins_ff[2];
    assign O_N_OE       = pins_ff[1];
    assign O_N_OUT      = pins_ff[0];
    assign O_FORMAT     = fmt_sel;
    assign O_POS_MODE   = modep;
    assign O_NEG_MODE   = moden;
    assign O_DIV_BYPASS = bypass_w;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence ctl_write_s;
        ctl_wr && !I_NVM_LOAD;
    endsequence

    sequence cmos_s;
        fmt_sel == oc7_pkg::OC7_FMT_CMOS;
    endsequence

    sequence ref_src_s;
        is_ref(src_sel);
    endsequence

    reset_value_a: assert property (
        disable iff (1'b0) !I_RESET_N |=> ctl_ff == `OC7_CTL_RESET)
        else $error("Control register not at reset value.");

    write_store_a: assert property (
        ctl_write_s |=> ctl_ff == $past(I_HWDATA[7:0]))
        else $error("Control write not stored.");

    src_mux_a: assert property (
        src_sel == oc7_pkg::OC7_SRC_PRIREF && $past(I_RESET_N) &&
        $past(I_RESET_N, 2) |-> src_w == $past(I_PRI_REF, 2))
        else $error("Primary reference not routed.");

    ref_bypass_a: assert property (
        is_ref(src_sel) && fmt_sel == oc7_pkg::OC7_FMT_ACDF
        |=> O_P_OUT == $past(src_w) && O_N_OUT == !$past(src_w))
        else $error("Reference not passed around divider.");

    fmt_off_a: assert property (
        fmt_sel == oc7_pkg::OC7_FMT_OFF |=> !O_P_OE && !O_N_OE)
        else $error("Disabled output still driven.");

    pos_low_a: assert property (
        cmos_s ##0 modep == oc7_pkg::OC7_PIN_LOW |=> O_P_OE && !O_P_OUT)
        else $error("Positive pin not driven low.");

    pos_true_a: assert property (
        cmos_s ##0 modep == oc7_pkg::OC7_PIN_TRUE
        |=> O_P_OE && O_P_OUT == $past(chan_w))
        else $error("Positive pin not true polarity.");

    neg_tri_a: assert property (
        cmos_s ##0 moden == oc7_pkg::OC7_PIN_TRI |=> !O_N_OE)
        else $error("Negative pin not tri-stated.");

    neg_inv_a: assert property (
        cmos_s ##0 moden == oc7_pkg::OC7_PIN_INV
        |=> O_N_OE && O_N_OUT == !$past(chan_w))
        else $error("Negative pin not inverted.");

    ref_hold_a: assert property (
        ref_src_s |=> cnt_ff == 8'h00)
        else $error("Divider counts on a reference source.");

    pll_divide_a: assert property (
        !is_ref(src_sel) && I_DIV_RATIO != 8'h00 && src_w && !prev_ff
        |=> cnt_ff != $past(cnt_ff))
        else $error("Divider ignores a PLL edge.");

    nvm_load_a: assert property (
        I_NVM_LOAD |=> ctl_ff == $past(I_NVM_DATA))
        else $error("Stored image not loaded.");

    ctl_hold_a: assert property (
        !ctl_wr && !I_NVM_LOAD |=> $stable(ctl_ff))
        else $error("Control register changed unwritten.");

    fmt_diff_a: assert property (
        fmt_sel == oc7_pkg::OC7_FMT_HCSL
        |=> O_P_OE && O_N_OE && O_N_OUT == !O_P_OUT)
        else $error("Differential pins not complementary.");

    pos_tri_a: assert property (
        cmos_s ##0 modep == oc7_pkg::OC7_PIN_TRI |=> !O_P_OE)
        else $error("Positive pin not tri-stated.");

    pos_inv_a: assert property (
        cmos_s ##0 modep == oc7_pkg::OC7_PIN_INV
        |=> O_P_OE && O_P_OUT == !$past(chan_w))
        else $error("Positive pin not inverted.");

    neg_low_a: assert property (
        cmos_s ##0 moden == oc7_pkg::OC7_PIN_LOW |=> O_N_OE && !O_N_OUT)
        else $error("Negative pin not driven low.");

    neg_true_a: assert property (
        cmos_s ##0 moden == oc7_pkg::OC7_PIN_TRUE
        |=> O_N_OE && O_N_OUT == $past(chan_w))
        else $error("Negative pin not true polarity.");

endmodule
`default_nettype wire

/* design/oc7_pkg.sv */
// Types for the output 7 channel control register block.
`default_nettype none
package oc7_pkg;
    typedef enum logic [1:0] {
        OC7_SRC_PLL1   = 2'h0,
        OC7_SRC_PLL2   = 2'h1,
        OC7_SRC_PRIREF = 2'h2,
        OC7_SRC_SECREF = 2'h3
    } oc7_src_t;
    typedef enum logic [1:0] {
        OC7_FMT_OFF  = 2'h0,
        OC7_FMT_ACDF = 2'h1,
        OC7_FMT_HCSL = 2'h2,
        OC7_FMT_CMOS = 2'h3
    } oc7_fmt_t;
    typedef enum logic [1:0] {
        OC7_PIN_TRI  = 2'h0,
        OC7_PIN_LOW  = 2'h1,
        OC7_PIN_INV  = 2'h2,
        OC7_PIN_TRUE = 2'h3
    } oc7_pin_t;
endpackage
`default_nettype wire

/* test/tb_output7_channel_control.sv */
// Self-checking bench for the output 7 channel control register.
`include "oc7_consts.svh"
`default_nettype none
module tb_output7_channel_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CTL = {`OC7_CTL_INDEX, 2'h0};
    localparam logic [31:0] STAT = {`OC7_STAT_INDEX, 2'h0};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        nvm_ld = 1'b0;
    logic [7:0]  nvm_d = 8'h0;
    logic [3:0]  src = 4'h0;
    logic [7:0]  ratio = 8'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        p_out, p_oe, n_out, n_oe, byp;
    logic [7:0]  nvm_q;
    logic [1:0]  fmt, pmode, nmode;
    int          miscompares = 0;
    int          checks_done = 0;

    oc7_output7_control oc7_output7_control_inst (
        .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_NVM_LOAD(nvm_ld), .I_NVM_DATA(nvm_d), .O_NVM_DATA(nvm_q),
        .I_PLL1_CLK(src[0]), .I_PLL2_CLK(src[1]), .I_PRI_REF(src[2]),
        .I_SEC_REF(src[3]), .I_DIV_RATIO(ratio),
        .O_P_OUT(p_out), .O_P_OE(p_oe), .O_N_OUT(n_out), .O_N_OE(n_oe),
        .O_FORMAT(fmt), .O_POS_MODE(pmode), .O_NEG_MODE(nmode),
        .O_DIV_BYPASS(byp)
    );

    always #10 clk = ~clk;

    task automatic end_of_test;
        $display("TB: checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for hready at a rising edge; a stuck bus ends the run.
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            miscompares++;
            end_of_test;
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= `OC7_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
        chk("hresp", hresp, 32'h0);
    endtask

    // Returns {oe, out} of one pin in single-ended format.
    function automatic logic [1:0] pm(logic [1:0] m, logic ch);
        case (m)
            2'h0: return 2'b00;
            2'h1: return 2'b10;
            2'h2: return {1'b1, ~ch};
            default: return {1'b1, ch};
        endcase
    endfunction

    // Pin levels are compared only where the pin is expected to drive.
    function automatic logic [3:0] exp_pins(logic [7:0] c, logic ch);
        if (c[5:4] == 2'h0)
            return 4'h0;
        if (c[5:4] != 2'h3)
            return {1'b1, ch, 1'b1, ~ch};
        return {pm(c[3:2], ch), pm(c[1:0], ch)};
    endfunction

    initial begin
        logic [31:0] q;
        logic [7:0]  c;
        logic        s;
        void'($urandom(32'h8a206af9));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, CTL, 32'h0, q);
        chk("reset ctl", q, 32'h18);
        chk("reset fields", {fmt, pmode, nmode, byp}, 7'h30);
        // First half walks every source and format, second every mode pair.
        for (int i = 0; i < 32; i++) begin
            c = 8'($urandom);
            if (i < 16)
                c[7:4] = i[3:0];
            else
                c = {c[7:6], 2'h3, i[3:0]};
            src <= 4'($urandom);
            ratio <= c[7] ? 8'($urandom) : 8'h0;
            bus(1'b1, CTL, {24'h0, c}, q);
            bus(1'b0, CTL, 32'h0, q);
            chk("ctl readback", q, {24'h0, c});
            repeat (4) @(posedge clk);
            chk("bypass", byp, c[7]);
            chk("format", fmt, c[5:4]);
            chk("pos mode", pmode, c[3:2]);
            chk("neg mode", nmode, c[1:0]);
            chk("nvm image", nvm_q, c);
            chk("pins", {p_oe, p_oe & p_out, n_oe, n_oe & n_out},
                exp_pins(c, src[c[7:6]]));
            s = src[c[7:6]];
            bus(1'b0, STAT, 32'h0, q);
            chk("status", q, {24'h0, exp_pins(c, s), 1'b0, c[7], s, s});
        end
        bus(1'b1, 32'h0, 32'hff, q);
        bus(1'b0, 32'h0, 32'h0, q);
        chk("unmapped read", q, 32'h0);
        bus(1'b0, CTL, 32'h0, q);
        chk("ctl kept", q, {24'h0, c});
        // A PLL source with ratio 1 halves the edge rate; a reference does not.
        ratio <= 8'h01;
        for (int k = 0; k < 2; k++) begin
            int   flips;
            logic last;
            bus(1'b1, CTL, {24'h0, k[0] ? 8'hbc : 8'h3c}, q);
            repeat (4) @(posedge clk);
            flips = 0;
            last = p_out;
            repeat (8) begin
                src <= src ^ (k[0] ? 4'h4 : 4'h1);
                repeat (6) @(posedge clk);
                flips += int'(p_out != last);
                last = p_out;
            end
            chk("edge rate", flips, k[0] ? 8 : 4);
        end
        nvm_d <= 8'h9e;
        nvm_ld <= 1'b1;
        @(posedge clk);
        nvm_ld <= 1'b0;
        bus(1'b0, CTL, 32'h0, q);
        chk("nvm load", q, 32'h9e);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, CTL, 32'h0, q);
        chk("second reset", q, 32'h18);
        end_of_test;
    end
endmodule
`default_nettype wire
